// ===== hdl/dbc_defs.vh
`ifndef DBC_DEFS_VH
`define DBC_DEFS_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define DBC_ADDR_W          12
`define DBC_ADDR_CFG        12'h000
`define DBC_ADDR_CTRL       12'h004
`define DBC_ADDR_STAT       12'h008

// ---------------------------------------------------------------
// dram_configuration field positions
// ---------------------------------------------------------------
`define DBC_BEN01_LSB       0
`define DBC_SD01_BIT        2
`define DBC_GAP01_LSB       8
`define DBC_LAT01_LSB       12
`define DBC_REC01_LSB       14
`define DBC_BEN23_LSB       16
`define DBC_SD23_BIT        18
`define DBC_GAP23_LSB       24
`define DBC_LAT23_LSB       28
`define DBC_REC23_LSB       30
`define DBC_CFG_RESET       32'h00000000

// ---------------------------------------------------------------
// control register fields (clock halving and extra half cas)
// ---------------------------------------------------------------
`define DBC_CTRL_HALF0_BIT  0
`define DBC_CTRL_HALF2_BIT  1
`define DBC_CTRL_XCAS0_BIT  2
`define DBC_CTRL_XCAS2_BIT  3
`define DBC_CTRL_W          4
`define DBC_CTRL_RESET      4'h0

// ---------------------------------------------------------------
// timer width
// ---------------------------------------------------------------
`define DBC_TMR_W           6

`endif

// ===== hdl/dbc_sync.v
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// two flip-flop level synchroniser
// ---------------------------------------------------------------
module dbc_sync (
    input  wire clk,
    input  wire rst_n,
    input  wire d,
    output wire q
);

    reg meta_q;
    reg sync_q;

    // first stage is read only by the second stage
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

`default_nettype wire

// ===== hdl/dbc_timer.v
`timescale 1ns/1ps
`default_nettype none

// ---------------------------------------------------------------
// loadable down counter, counts enable pulses
// ---------------------------------------------------------------
module dbc_timer #(
    parameter W = 6
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire         load,
    input  wire [W-1:0] load_val,
    input  wire         ce,
    output wire         done
);

    reg [W-1:0] count_q;

    // load wins over a pending decrement
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {W{1'b0}};
        end else if (load) begin
            count_q <= load_val;
        end else if (ce && (count_q != {W{1'b0}})) begin
            count_q <= count_q - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count_q == {W{1'b0}});

endmodule

`default_nettype wire

// ===== hdl/dbc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "dbc_defs.vh"

module dbc_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        sleep_reset,
    input  wire        mem_clk_in,
    input  wire        mem_req,
    input  wire        mem_write,
    input  wire [1:0]  mem_bank,
    input  wire        mem_burst,
    input  wire        mem_autopre,
    output wire        mem_ack,
    output wire        read_capture,
    output wire [3:0]  row_strobe_n,
    output wire [3:0]  sdram_chip_select_n,
    output wire        column_strobe_n,
    output wire        refresh_count_en,
    output wire        cbr_busy
);

    // ---------------------------------------------------------------
    // state codes
    // ---------------------------------------------------------------
    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_ROW   = 3'h1;
    localparam [2:0] S_COL   = 3'h2;
    localparam [2:0] S_LATCH = 3'h3;
    localparam [2:0] S_HALF  = 3'h4;
    localparam [2:0] S_CBRC  = 3'h5;
    localparam [2:0] S_CBRR  = 3'h6;

    // ---------------------------------------------------------------
    // timing arithmetic
    // ---------------------------------------------------------------
    // precharge gap in memory ticks
    function [5:0] gap_len;
        input [3:0] gap_code;
        input [1:0] rec_code;
        input       sd;
        input       half;
        input       wr;
        begin
            gap_len = {2'h0, gap_code} + 6'h01
                    + {5'h00, sd & half}
                    + ((sd & wr) ? {4'h0, rec_code} : 6'h00);
        end
    endfunction

    // read latch wait; async in pclk, sdram in sdram ticks
    function [5:0] latch_len;
        input [1:0] lat_code;
        input       sd;
        input       half;
        begin
            if (!sd) begin
                latch_len = {4'h0, lat_code};
            end else if (lat_code == 2'h0) begin
                latch_len = 6'h01;                        // reserved code, treat as one
            end else begin
                latch_len = {4'h0, lat_code};
            end
        end
    endfunction

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    reg [31:0]               cfg_q;
    reg [`DBC_CTRL_W-1:0]    ctrl_q;
    reg [31:0]               prdata_q;
    reg [2:0]                state_q;
    reg [1:0]                bank_q;
    reg                      wr_q;
    reg                      ap_q;
    reg                      ph_q;
    reg                      clk_prev_q;
    reg                      ack_q;
    reg                      cap_q;
    reg [3:0]                row_n_q;
    reg [3:0]                cs_n_q;
    reg                      col_n_q;

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    wire hit_cfg  = (paddr == `DBC_ADDR_CFG);
    wire hit_ctrl = (paddr == `DBC_ADDR_CTRL);
    wire hit_stat = (paddr == `DBC_ADDR_STAT);
    wire mapped   = hit_cfg | hit_ctrl | hit_stat;
    wire acc      = psel & penable;
    wire wr_en    = acc & pwrite;

    // zero wait states; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = prdata_q;

    // ---------------------------------------------------------------
    // configuration views for the accessed pair
    // ---------------------------------------------------------------
    wire [3:0] ben_w = {cfg_q[`DBC_BEN23_LSB +: 2], cfg_q[`DBC_BEN01_LSB +: 2]};
    wire       sd0   = cfg_q[`DBC_SD01_BIT];
    wire       sd2   = cfg_q[`DBC_SD23_BIT];
    wire       pair = bank_q[1];
    // upper fields decode through the same paths as the lower ones
    wire [3:0] gap_w   = pair ? cfg_q[`DBC_GAP23_LSB +: 4] : cfg_q[`DBC_GAP01_LSB +: 4];
    wire [1:0] lat_w   = pair ? cfg_q[`DBC_LAT23_LSB +: 2] : cfg_q[`DBC_LAT01_LSB +: 2];
    wire [1:0] rec_w   = pair ? cfg_q[`DBC_REC23_LSB +: 2] : cfg_q[`DBC_REC01_LSB +: 2];
    wire       sd_w    = pair ? sd2 : sd0;
    wire       half_w  = pair ? ctrl_q[`DBC_CTRL_HALF2_BIT] : ctrl_q[`DBC_CTRL_HALF0_BIT];
    wire       xhalf_w = pair ? ctrl_q[`DBC_CTRL_XCAS2_BIT] : ctrl_q[`DBC_CTRL_XCAS0_BIT];
    wire       req_sd  = mem_bank[1] ? sd2 : sd0;

    // flags for sdram pairs left with a zero gap; hardware does not guard it
    wire gap_bad0 = sd0 & (cfg_q[`DBC_GAP01_LSB +: 4] == 4'h0);
    wire gap_bad2 = sd2 & (cfg_q[`DBC_GAP23_LSB +: 4] == 4'h0);

    // ---------------------------------------------------------------
    // memory clock edges and sdram rate
    // ---------------------------------------------------------------
    wire clk_s;

    dbc_sync u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     (mem_clk_in),
        .q     (clk_s)
    );

    wire tick    = clk_s & ~clk_prev_q;
    wire fall    = ~clk_s & clk_prev_q;
    // half rate sdram clock advances on every other memory tick
    wire sd_tick = tick & (~half_w | ph_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_prev_q <= 1'b0;
            ph_q       <= 1'b0;
        end else begin
            clk_prev_q <= clk_s;
            if (tick) begin
                ph_q <= ~ph_q;
            end
        end
    end

    // ---------------------------------------------------------------
    // transfer end conditions and timers
    // ---------------------------------------------------------------
    wire latch_done;
    wire gap_done;
    wire col_done = (state_q == S_COL) & tick;
    wire wr_done  = col_done & wr_q;
    // capture after the latch wait, or on the next falling edge with the extra half
    wire rd_done  = ((state_q == S_LATCH) & latch_done & ~(sd_w & xhalf_w))
                  | ((state_q == S_HALF) & fall);
    wire cbr_done = (state_q == S_CBRR) & tick;
    wire gap_load = wr_done | rd_done | cbr_done;
    wire lat_load = col_done & ~wr_q;
    // async latch counts processor clocks, sdram counts sdram clocks
    wire lat_ce   = sd_w ? sd_tick : 1'b1;

    // autoprecharge read gap starts at data latch, one column tick after the
    // command plus the latch wait, giving latch plus gap plus two overall
    wire [5:0] gap_val = gap_len(gap_w, rec_w, sd_w, half_w, wr_done);
    wire [5:0] lat_val = latch_len(lat_w, sd_w, half_w);

    dbc_timer #(.W(`DBC_TMR_W)) u_gap (
        .clk      (pclk),
        .rst_n    (presetn),
        .load     (gap_load),
        .load_val (gap_val),
        .ce       (tick),
        .done     (gap_done)
    );

    dbc_timer #(.W(`DBC_TMR_W)) u_latch (
        .clk      (pclk),
        .rst_n    (presetn),
        .load     (lat_load),
        .load_val (lat_val),
        .ce       (lat_ce),
        .done     (latch_done)
    );

    // ---------------------------------------------------------------
    // register writes and read data
    // ---------------------------------------------------------------
    // sleep reset clears only the bank enables and wins over a write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q  <= `DBC_CFG_RESET;
            ctrl_q <= `DBC_CTRL_RESET;
        end else begin
            if (wr_en && hit_cfg) begin
                cfg_q <= pwdata;
            end
            if (wr_en && hit_ctrl) begin
                ctrl_q <= pwdata[`DBC_CTRL_W-1:0];
            end
            if (sleep_reset) begin
                cfg_q[`DBC_BEN01_LSB +: 2] <= 2'h0;
                cfg_q[`DBC_BEN23_LSB +: 2] <= 2'h0;
            end
        end
    end

    // read data captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (hit_cfg) begin
                prdata_q <= cfg_q;
            end else if (hit_ctrl) begin
                prdata_q <= {28'h0000000, ctrl_q};
            end else if (hit_stat) begin
                prdata_q <= {22'h000000, gap_bad2, gap_bad0, 1'b0, state_q,
                             1'b0, ~gap_done, refresh_count_en, (state_q != S_IDLE)};
            end else begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // access sequencer
    // ---------------------------------------------------------------
    // strobes stay high while the gap timer runs, so idle time is the gap
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_IDLE;
            bank_q  <= 2'h0;
            wr_q    <= 1'b0;
            ap_q    <= 1'b0;
            ack_q   <= 1'b0;
            cap_q   <= 1'b0;
            row_n_q <= 4'hF;
            cs_n_q  <= 4'hF;
            col_n_q <= 1'b1;
        end else begin
            ack_q <= 1'b0;
            cap_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (mem_req && gap_done && tick) begin
                        bank_q <= mem_bank;
                        wr_q   <= mem_write;
                        ap_q   <= mem_autopre;
                        if (ben_w[mem_bank]) begin
                            state_q <= S_ROW;
                            if (req_sd) begin
                                cs_n_q[mem_bank] <= 1'b0;
                            end else begin
                                row_n_q[mem_bank] <= 1'b0;
                            end
                        end else if (!mem_burst) begin
                            state_q <= S_CBRC;
                            col_n_q <= 1'b0;
                        end else begin
                            ack_q <= 1'b1;
                        end
                    end
                end
                S_ROW: begin
                    if (tick) begin
                        col_n_q <= 1'b0;
                        state_q <= S_COL;
                    end
                end
                S_COL: begin
                    if (tick) begin
                        col_n_q <= 1'b1;
                        if (wr_q) begin
                            ack_q   <= 1'b1;
                            row_n_q <= 4'hF;
                            cs_n_q  <= 4'hF;
                            state_q <= S_IDLE;
                        end else begin
                            state_q <= S_LATCH;
                        end
                    end
                end
                S_LATCH: begin
                    if (latch_done) begin
                        if (sd_w && xhalf_w) begin
                            state_q <= S_HALF;
                        end else begin
                            cap_q   <= 1'b1;
                            ack_q   <= 1'b1;
                            row_n_q <= 4'hF;
                            cs_n_q  <= 4'hF;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_HALF: begin
                    if (fall) begin
                        cap_q   <= 1'b1;
                        ack_q   <= 1'b1;
                        row_n_q <= 4'hF;
                        cs_n_q  <= 4'hF;
                        state_q <= S_IDLE;
                    end
                end
                S_CBRC: begin
                    if (tick) begin
                        row_n_q <= 4'h0;
                        cs_n_q  <= 4'h0;
                        state_q <= S_CBRR;
                    end
                end
                S_CBRR: begin
                    if (tick) begin
                        row_n_q <= 4'hF;
                        cs_n_q  <= 4'hF;
                        col_n_q <= 1'b1;
                        ack_q   <= 1'b1;
                        state_q <= S_IDLE;
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    row_n_q <= 4'hF;
                    cs_n_q  <= 4'hF;
                    col_n_q <= 1'b1;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign mem_ack             = ack_q;
    assign read_capture        = cap_q;
    assign row_strobe_n        = row_n_q;
    assign sdram_chip_select_n = cs_n_q;
    assign column_strobe_n     = col_n_q;
    assign cbr_busy            = (state_q == S_CBRC) | (state_q == S_CBRR);
    // refresh stops once every bank is disabled
    assign refresh_count_en    = |ben_w;

endmodule

`default_nettype wire

// ===== verification/dbc_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module dbc_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sleep_reset,
    input wire logic        mem_ack,
    input wire logic        read_capture,
    input wire logic [3:0]  row_strobe_n,
    input wire logic [3:0]  sdram_chip_select_n,
    input wire logic        column_strobe_n,
    input wire logic        refresh_count_en,
    input wire logic        cbr_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // every bank precharging
    wire idle = &row_strobe_n && &sdram_chip_select_n;
    wire cfg_wr = psel && penable && pwrite && paddr == 12'h000;
    // refresh: column first, done within two ticks plus margin
    sequence s_cbr_body;
        ##[0:2] !column_strobe_n ##[1:60] mem_ack;
    endsequence
    // gap 0 still means one whole tick, so six cycles is safe
    a_gap_hold: assert property ($rose(idle) |-> idle[*6])
        else $error("precharge gap too short");
    a_capture_ack: assert property (read_capture |-> mem_ack && column_strobe_n)
        else $error("read capture without ack");
    a_ack_pulse: assert property (mem_ack |=> !mem_ack)
        else $error("ack longer than one cycle");
    a_refresh_run: assert property (cfg_wr && !sleep_reset |=>
        refresh_count_en == ($past(|pwdata[17:16]) || $past(|pwdata[1:0])))
        else $error("refresh enable wrong after write");
    a_sleep_stop: assert property (sleep_reset |=> !refresh_count_en)
        else $error("sleep reset left a bank enabled");
    a_cbr_seq: assert property ($rose(cbr_busy) |-> s_cbr_body)
        else $error("refresh sequence wrong");
    a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0 |->
        pslverr == (paddr > 12'h008))
        else $error("slave error wrong");
    a_ready_high: assert property (pready)
        else $error("ready low");
endmodule
bind dbc_top dbc_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .sleep_reset(sleep_reset), .mem_ack(mem_ack), .read_capture(read_capture),
    .row_strobe_n(row_strobe_n), .sdram_chip_select_n(sdram_chip_select_n),
    .column_strobe_n(column_strobe_n), .refresh_count_en(refresh_count_en),
    .cbr_busy(cbr_busy));
`default_nettype wire

// ===== verification/dbc_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// memory side: free running clock, precharge gap meter
// ---------------------------------------------------------------
module dbc_mem_model (
    output logic             mem_clk,
    input  wire logic [3:0]  row_strobe_n,
    input  wire logic [3:0]  sdram_chip_select_n,
    output logic      [7:0]  gap_ticks
);
    int  run = 0;
    wire idle = &row_strobe_n & &sdram_chip_select_n;
    // odd start offset keeps the phase unrelated to the bus clock
    initial begin
        mem_clk = 1'h0;
        gap_ticks = 8'h00;
        #7;
        forever #80 mem_clk = ~mem_clk;
    end
    // count memory edges while all banks precharge; keep the last span
    always @(posedge mem_clk or negedge idle) begin
        if (!idle) begin
            if (run != 0) gap_ticks <= run[7:0];
            run <= 0;
        end else begin
            run <= run + 1;
        end
    end
endmodule
`default_nettype wire

// ===== verification/test_dram_bank_config_timing.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbc_defs.vh"
module test_dram_bank_config_timing;
    logic        pclk, presetn, psel, penable, pwrite, sleep_reset, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        mem_clk_in, mem_req, mem_write, mem_burst, mem_autopre, mem_ack;
    logic        read_capture, column_strobe_n, refresh_count_en, cbr_busy;
    logic [1:0]  mem_bank;
    logic [3:0]  row_strobe_n, sdram_chip_select_n;
    logic [7:0]  gap_ticks;
    int          fails = 0, samples_checked = 0, lat, i;
    logic        cbr;
    // cases: config, control, bank, write, minimum gap ticks, latency window
    logic [31:0] t_cfg [10] = '{32'h0000_0301, 32'hC205_0000, 32'hC205_0000, 32'h0000_C102,
        32'h0000_0001, 32'h0000_2001, 32'h0000_3001, 32'h0000_2106, 32'h0000_2106,
        32'h0000_2106};
    logic [31:0] t_ctl [10] = '{0, 0, 2, 0, 0, 0, 0, 0, 1, 4};
    logic [1:0]  t_bank [10] = '{0, 2, 2, 1, 0, 0, 0, 1, 1, 1};
    logic        t_wr [10] = '{1, 1, 1, 1, 0, 0, 0, 0, 0, 0};
    int          t_gap [10] = '{4, 6, 7, 2, 1, 1, 1, 2, 3, 2};
    int          t_lo [10] = '{0, 0, 0, 0, 0, 2, 3, 8, 24, 16};
    int          t_hi [10] = '{0, 0, 0, 0, 3, 5, 6, 20, 36, 24};
    dbc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep_reset(sleep_reset), .mem_clk_in(mem_clk_in),
        .mem_req(mem_req), .mem_write(mem_write), .mem_bank(mem_bank),
        .mem_burst(mem_burst), .mem_autopre(mem_autopre), .mem_ack(mem_ack),
        .read_capture(read_capture), .row_strobe_n(row_strobe_n),
        .sdram_chip_select_n(sdram_chip_select_n), .column_strobe_n(column_strobe_n),
        .refresh_count_en(refresh_count_en), .cbr_busy(cbr_busy));
    dbc_mem_model u_mem (.mem_clk(mem_clk_in), .row_strobe_n(row_strobe_n),
        .sdram_chip_select_n(sdram_chip_select_n), .gap_ticks(gap_ticks));
    initial begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end
    // ---------------------------------------------------------------
    // checking and reporting
    // ---------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("compares %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic timeout();
        fails++;
        $display("wait limit hit at %0t", $time);
        results();
    endtask
    // ---------------------------------------------------------------
    // bus tasks
    // ---------------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            n++;
            if (n > 100) timeout();
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    // request held until ack; latency is column release to capture
    task automatic mem_op(input logic [1:0] b, input logic w, input logic bu);
        int n, last_low;
        n = 0;
        last_low = 0;
        lat = -1;
        cbr = 1'h0;
        mem_req <= 1'h1;
        mem_write <= w;
        mem_bank <= b;
        mem_burst <= bu;
        mem_autopre <= 1'h1;
        @(posedge pclk);
        while (mem_ack !== 1'h1) begin
            n++;
            if (n > 4000) timeout();
            if (column_strobe_n === 1'h0) last_low = n;
            if (cbr_busy === 1'h1) cbr = 1'h1;
            @(posedge pclk);
        end
        if (read_capture === 1'h1) lat = n - last_low;
        mem_req <= 1'h0;
        @(posedge pclk);
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, sleep_reset, paddr, pwdata} = '0;
        {mem_req, mem_write, mem_bank, mem_burst, mem_autopre} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        apb(1'h0, `DBC_ADDR_CFG, 32'h0);
        chk(rd, `DBC_CFG_RESET);
        chk({31'h0, refresh_count_en}, 32'h0);
        apb(1'h1, `DBC_ADDR_CFG, 32'hFFFF_FFFF);
        apb(1'h0, `DBC_ADDR_CFG, 32'h0);
        chk(rd, 32'hFFFF_FFFF);
        chk({31'h0, refresh_count_en}, 32'h1);
        apb(1'h1, `DBC_ADDR_CTRL, 32'hFFFF_FFFF);
        apb(1'h0, `DBC_ADDR_CTRL, 32'h0);
        chk(rd, 32'h0000_000F);
        apb(1'h0, 12'h00C, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        sleep_reset <= 1'h1;
        @(posedge pclk);
        sleep_reset <= 1'h0;
        apb(1'h0, `DBC_ADDR_CFG, 32'h0);
        chk(rd, 32'hFFFC_FFFC);
        chk({31'h0, refresh_count_en}, 32'h0);
        // both pairs sdram with a zero gap: status raises both warning bits
        apb(1'h1, `DBC_ADDR_CFG, 32'h0004_0004);
        apb(1'h0, `DBC_ADDR_STAT, 32'h0);
        chk(rd, 32'h0000_0300);
        $display("register test done");
        // sdram cases keep the gap at one or more; case 8 sets pair 0/1 clock halving
        for (i = 0; i < 10; i++) begin
            apb(1'h1, `DBC_ADDR_CFG, t_cfg[i]);
            apb(1'h1, `DBC_ADDR_CTRL, t_ctl[i]);
            repeat (2) mem_op(t_bank[i], t_wr[i], 1'h0);
            chk({31'h0, gap_ticks >= t_gap[i] && gap_ticks <= t_gap[i] + 2}, 32'h1);
            if (!t_wr[i]) chk({31'h0, lat >= t_lo[i] && lat <= t_hi[i]}, 32'h1);
        end
        $display("timing test done");
        apb(1'h1, `DBC_ADDR_CFG, 32'h0000_0001);
        mem_op(2'h3, 1'h1, 1'h0);
        chk({31'h0, cbr}, 32'h1);
        mem_op(2'h3, 1'h0, 1'h1);
        chk({31'h0, cbr}, 32'h0);
        $display("refresh test done");
        results();
    end
endmodule
`default_nettype wire
